// ==== hdl/timer_ext_irq_consts.svh ====
// constants for the timer and external interrupt unit
// included by the unit module and the bench
`ifndef TIMER_EXT_IRQ_CONSTS_SVH
`define TIMER_EXT_IRQ_CONSTS_SVH

`define OFS_CTRL        8'h00
`define OFS_COUNT       8'h04
`define OFS_RELOAD      8'h08
`define OFS_STATUS      8'h0C
`define OFS_ALLOW       8'h10

`define BIT_EXT_EN      0
`define BIT_TMR_EN      1
`define BIT_LEVEL       2
`define BIT_RUN         3
`define BIT_PWM         4
`define BIT_DIV2        5
`define BIT_DIV5        6
`define BIT_DIV20       7

`define CTRL_RST        8'h00
`define COUNT_RST       8'h00
`define VEC_TIMER       12'h020
`define VEC_EXT         12'h0A0
`define PHI_DIV         4'h2
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ==== hdl/timer_ext_irq_pkg.sv ====
// types shared by the timer and external interrupt unit
// no clock or reset assumptions
package timer_ext_irq_pkg;
  typedef enum logic [1:0] {MODE_INTERVAL, MODE_PWM, MODE_EVENT} timer_mode_e;
  typedef enum logic [1:0] {ST_IDLE, ST_VECTOR, ST_ACK} irq_state_e;
endpackage

// ==== hdl/prescaler.sv ====
// phase clock prescaler, divide by 2, 5, 20 and their products
// runs on phase enable pulses from the parent, cleared synchronously
`timescale 1ns/1ps
module prescaler
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       phi_en,
  input  wire logic       run,
  input  wire logic       clr,
  input  wire logic [2:0] sel,
  output logic            tick
);
  logic [7:0] div;
  logic [7:0] cnt;

  always_comb
  begin
    div = 8'h01;
    if (sel[0])
      div = 8'h02;
    if (sel[1])
      div = 8'(div * 8'h05);
    if (sel[2])
      div = 8'(div * 8'h14);
  end

  // intermediate count stays internal, no read path
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clr)
      cnt <= 8'h00;
    else if (phi_en && run)
      cnt <= (cnt == 8'(div - 8'h01)) ? 8'h00 : 8'(cnt + 8'h01);
  end

  assign tick = phi_en && run && !clr && (cnt == 8'(div - 8'h01));
endmodule

// ==== hdl/timer_ext_interrupt_unit.sv ====
// 8-bit down timer with reload, event pin and vectored interrupt requests
// AXI4-Lite slave; core handshake and event pin synchronous to aclk
`timescale 1ns/1ps
`include "timer_ext_irq_consts.svh"
module timer_ext_interrupt_unit
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        event_pin,
  input  wire logic        instr_done,
  input  wire logic [15:0] return_addr,
  output logic             irq_pending,
  output logic             vector_valid,
  output logic [11:0]      vector_data,
  output logic [15:0]      stack_reg,
  output timer_ext_irq_pkg::irq_state_e irq_state
);
  import timer_ext_irq_pkg::*;

  logic [7:0]  timer_irq_control_port;
  logic [7:0]  cnt;
  logic [7:0]  reload;
  logic        global_irq_allow_bit;
  logic        tmr_latch;
  logic        ext_latch;
  logic [3:0]  phi_cnt;
  logic        phi_en;
  logic        pin_q;
  logic        act_q;
  logic        act;
  logic        rise;
  logic        fall;
  logic        tick;
  logic        dec;
  logic        pre_run;
  logic        pre_clr;
  logic        tmr_req;
  logic        ext_req;
  logic        serve_tmr;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;
  logic        cnt_wr;
  logic        ack_tmr;
  logic        ack_ext;
  timer_mode_e mode;

  // phase clock enable divider
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      phi_cnt <= 4'h0;
    else
      phi_cnt <= (phi_cnt == 4'(`PHI_DIV - 4'h1)) ? 4'h0 : 4'(phi_cnt + 4'h1);
  end
  assign phi_en = (phi_cnt == 4'h0);

  always_comb
  begin
    if (timer_irq_control_port[`BIT_PWM])
      mode = MODE_PWM;
    else if (timer_irq_control_port[`BIT_DIV20:`BIT_DIV2] == 3'h0)
      mode = MODE_EVENT;
    else
      mode = MODE_INTERVAL;
  end

  // pin level select, sampled per phase clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_q <= 1'b0;
      // low pin with level bit clear reads active, so no false edge after reset
      act_q <= 1'b1;
    end
    else if (phi_en)
    begin
      pin_q <= event_pin;
      act_q <= act;
    end
  end
  // one sample per phase clock relies on the source's two-period minimum
  assign act  = pin_q ~^ timer_irq_control_port[`BIT_LEVEL];
  assign rise = phi_en && act && !act_q;
  assign fall = phi_en && !act && act_q;

  assign pre_run = timer_irq_control_port[`BIT_RUN] && (mode != MODE_EVENT)
                   && (mode != MODE_PWM || act);
  assign pre_clr = !pre_run || cnt_wr;

  prescaler prescaler_inst
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .phi_en  (phi_en),
    .run     (pre_run),
    .clr     (pre_clr),
    .sel     (timer_irq_control_port[`BIT_DIV20:`BIT_DIV2]),
    .tick    (tick)
  );

  assign dec = timer_irq_control_port[`BIT_RUN]
               && ((mode == MODE_EVENT) ? rise : tick);

  // bus writes load counter and reload; a decrement at 1 reloads the counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt    <= `COUNT_RST;
      reload <= `COUNT_RST;
    end
    else if (cnt_wr)
    begin
      cnt    <= w_data[7:0];
      reload <= w_data[7:0];
    end
    else if (dec)
      cnt <= (cnt == 8'h01) ? reload : 8'(cnt - 8'h01);
  end

  // timer latch set, wins over ack
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tmr_latch <= 1'b0;
    else if (cnt_wr)
      tmr_latch <= 1'b0;
    else if (dec && cnt == 8'h01)
      tmr_latch <= 1'b1;
    else if (ack_tmr)
      tmr_latch <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ext_latch <= 1'b0;
    else if (!timer_irq_control_port[`BIT_EXT_EN])
      ext_latch <= 1'b0;
    else if ((mode == MODE_PWM) ? fall : rise)
      ext_latch <= 1'b1;
    else if (ack_ext)
      ext_latch <= 1'b0;
  end

  assign tmr_req     = tmr_latch && timer_irq_control_port[`BIT_TMR_EN];
  assign ext_req     = ext_latch && timer_irq_control_port[`BIT_EXT_EN];
  assign irq_pending = tmr_req || ext_req;
  assign ack_tmr     = (irq_state == ST_ACK) && serve_tmr;
  assign ack_ext     = (irq_state == ST_ACK) && !serve_tmr;

  // service sequence: take, present vector, acknowledge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_state    <= ST_IDLE;
      serve_tmr    <= 1'b0;
      vector_valid <= 1'b0;
      vector_data  <= 12'h000;
      stack_reg    <= 16'h0000;
    end
    else
    begin
      vector_valid <= 1'b0;
      case (irq_state)
        ST_IDLE:
        begin
          // take at instruction end when allowed
          if (instr_done && global_irq_allow_bit && irq_pending)
          begin
            serve_tmr    <= tmr_req;
            vector_data  <= tmr_req ? `VEC_TIMER : `VEC_EXT;
            vector_valid <= 1'b1;
            irq_state    <= ST_VECTOR;
          end
        end
        ST_VECTOR:
        begin
          stack_reg <= return_addr;
          irq_state <= ST_ACK;
        end
        ST_ACK:
          irq_state <= ST_IDLE;
        default:
          irq_state <= ST_IDLE;
      endcase
    end
  end

  // write channel; address and data accepted in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign wr_go         = aw_held && w_held && !s_axi_bvalid;
  assign cnt_wr        = wr_go && (aw_addr == `OFS_COUNT) && w_strb[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `OFS_CTRL || aw_addr == `OFS_COUNT || aw_addr == `OFS_ALLOW)
          s_axi_bresp <= `RESP_OKAY;
        else
          s_axi_bresp <= `RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_irq_control_port <= `CTRL_RST;
      global_irq_allow_bit   <= 1'b0;
    end
    else if (wr_go && w_strb[0])
    begin
      if (aw_addr == `OFS_CTRL)
        timer_irq_control_port <= w_data[7:0];
      else if (aw_addr == `OFS_ALLOW)
        global_irq_allow_bit <= w_data[0];
    end
  end

  // read channel, one outstanding read
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      // read has no side effect on counting
      if (s_axi_araddr == `OFS_CTRL)
        s_axi_rdata <= {24'h000000, timer_irq_control_port};
      else if (s_axi_araddr == `OFS_COUNT)
        s_axi_rdata <= {24'h000000, cnt};
      else if (s_axi_araddr == `OFS_RELOAD)
        s_axi_rdata <= {24'h000000, reload};
      else if (s_axi_araddr == `OFS_STATUS)
        s_axi_rdata <= {28'h0000000, global_irq_allow_bit, pin_q, tmr_latch, ext_latch};
      else if (s_axi_araddr == `OFS_ALLOW)
        s_axi_rdata <= {31'h00000000, global_irq_allow_bit};
      else
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `RESP_SLVERR;
      end
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  property p_wrap;
    @(posedge aclk) disable iff (!aresetn)
    (dec && !cnt_wr && cnt == 8'h01) |=> (cnt == $past(reload)) && tmr_latch;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap to reload failed");

  property p_load;
    @(posedge aclk) disable iff (!aresetn)
    cnt_wr |=> (cnt == $past(w_data[7:0])) && (reload == cnt) && !tmr_latch;
  endproperty
  a_load: assert property (p_load) else $error("counter load wrong");

  property p_stop;
    @(posedge aclk) disable iff (!aresetn)
    (!timer_irq_control_port[`BIT_RUN] && !cnt_wr) |=> $stable(cnt);
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved while stopped");

  property p_pwm_hold;
    @(posedge aclk) disable iff (!aresetn)
    (mode == MODE_PWM && !act && !cnt_wr) |=> $stable(cnt);
  endproperty
  a_pwm_hold: assert property (p_pwm_hold) else $error("count with pin inactive");

  property p_event_dec;
    @(posedge aclk) disable iff (!aresetn)
    (mode == MODE_EVENT && timer_irq_control_port[`BIT_RUN] && rise && !cnt_wr
     && cnt != 8'h01) |=> cnt == 8'($past(cnt) - 8'h01);
  endproperty
  a_event_dec: assert property (p_event_dec) else $error("event decrement missed");

  property p_ext_drop;
    @(posedge aclk) disable iff (!aresetn)
    !timer_irq_control_port[`BIT_EXT_EN] |=> !ext_latch;
  endproperty
  a_ext_drop: assert property (p_ext_drop) else $error("ext latch kept");

  property p_trail;
    @(posedge aclk) disable iff (!aresetn)
    (mode == MODE_PWM && fall && timer_irq_control_port[`BIT_EXT_EN]) |=> ext_latch;
  endproperty
  a_trail: assert property (p_trail) else $error("trailing edge not latched");

  property p_prio;
    @(posedge aclk) disable iff (!aresetn)
    (irq_state == ST_IDLE && instr_done && global_irq_allow_bit && tmr_req)
      |=> vector_valid && vector_data == `VEC_TIMER ##2 irq_state == ST_IDLE;
  endproperty
  a_prio: assert property (p_prio) else $error("timer vector not first");

  property p_hold;
    @(posedge aclk) disable iff (!aresetn)
    (irq_state == ST_IDLE && !global_irq_allow_bit) |=> irq_state == ST_IDLE;
  endproperty
  a_hold: assert property (p_hold) else $error("taken while not allowed");

  property p_reset;
    @(posedge aclk)
    !aresetn |=> timer_irq_control_port == `CTRL_RST && cnt == `COUNT_RST
                 && !global_irq_allow_bit;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
endmodule

// ==== tb/core_pin_model.sv ====
// core and event source model facing the timer unit
// assumes aclk rising edge and synchronous active-low reset
`timescale 1ns/1ps
module core_pin_model
#(
  parameter logic [15:0] RET_ADDR = 16'h3A5C
)
(
  input  wire logic   aclk,
  input  wire logic   aresetn,
  output logic        instr_done,
  output logic [15:0] return_addr,
  output logic        event_pin
);
  logic [1:0] phase;
  initial event_pin = 1'b0;
  assign return_addr = RET_ADDR;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      phase <= 2'h0;
    else
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
  end
  // held low in reset so no take can start early
  assign instr_done = aresetn && (phase == 2'h2);
  task set_pin(input logic lvl);
    @(posedge aclk);
    event_pin <= lvl;
  endtask
  task pulse(input logic act, input int n);
    repeat (n)
    begin
      set_pin(act);
      repeat (5) @(posedge aclk);
      set_pin(!act);
      repeat (5) @(posedge aclk);
    end
  endtask
endmodule

// ==== tb/timer_ext_interrupt_unit_bench.sv ====
// self-checking bench for the timer and external interrupt unit
// drives AXI4-Lite and the core model at aclk rising edges
`timescale 1ns/1ps
`include "timer_ext_irq_consts.svh"
module timer_ext_interrupt_unit_bench;
  import timer_ext_irq_pkg::*;
  localparam logic [15:0] RET = 16'h3A5C;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        event_pin;
  logic        instr_done;
  logic [15:0] return_addr;
  logic        irq_pending;
  logic        vector_valid;
  logic [11:0] vector_data;
  logic [15:0] stack_reg;
  irq_state_e  irq_state;
  int          mismatches;
  int          check_count;
  int          i;
  logic [31:0] d;
  logic [1:0]  r;
  logic [11:0] v;
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  timer_ext_interrupt_unit timer_ext_interrupt_unit_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_pin(event_pin),
    .instr_done(instr_done), .return_addr(return_addr),
    .irq_pending(irq_pending), .vector_valid(vector_valid),
    .vector_data(vector_data), .stack_reg(stack_reg), .irq_state(irq_state));
  core_pin_model #(.RET_ADDR(RET)) core_pin_model_inst (
    .aclk(aclk), .aresetn(aresetn), .instr_done(instr_done),
    .return_addr(return_addr), .event_pin(event_pin));
  task close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask
  task rst(input int n);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (n) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] x, output logic [1:0] resp);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, x};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (n == 40)
    begin
      mismatches++;
      close_out();
    end
  endtask
  task w(input logic [7:0] a, input logic [7:0] x);
    logic [1:0] resp;
    wr(a, x, resp);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] resp);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    x = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n == 40)
    begin
      mismatches++;
      close_out();
    end
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    logic [1:0]  resp;
    rd(a, x, resp);
    chk(x, exp);
  endtask
  // status polled by reads, bounded
  task poll(input int idx);
    logic [31:0] x;
    logic [1:0]  resp;
    for (int n = 0; n < 60; n++)
    begin
      rd(`OFS_STATUS, x, resp);
      if (x[idx] === 1'b1) break;
    end
    chk({31'h0, x[idx]}, 32'h1);
  endtask
  task wait_vec;
    int n;
    for (n = 0; n < 200; n++)
    begin
      @(posedge aclk);
      if (vector_valid === 1'b1) break;
    end
    v = vector_data;
    if (n == 200)
    begin
      mismatches++;
      close_out();
    end
  endtask
  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    mismatches = 0;
    check_count = 0;
    rst(16);
    for (i = 0; i < 5; i++) rchk(8'(i * 4), 32'h0);
    wr(8'h1C, 8'hFF, r);
    chk_resp(r, `RESP_SLVERR);
    rd(8'h1C, d, r);
    chk_resp(r, `RESP_SLVERR);
    w(`OFS_CTRL, 8'hA5);
    rchk(`OFS_CTRL, 32'hA5);
    w(`OFS_CTRL, 8'h00);
    // interval mode, divide by 2
    w(`OFS_COUNT, 8'h03);
    w(`OFS_CTRL, 8'h2A);
    poll(1);
    chk({31'h0, irq_pending}, 32'h1);
    w(`OFS_CTRL, 8'h00);
    rd(`OFS_COUNT, d, r);
    rchk(`OFS_COUNT, d);
    rchk(`OFS_RELOAD, 32'h3);
    rchk(`OFS_STATUS, 32'h2);
    chk({31'h0, irq_pending}, 32'h0);
    // interval mode, divide by 5 and by 20
    for (i = 0; i < 2; i++)
    begin
      w(`OFS_COUNT, 8'h02);
      w(`OFS_CTRL, (i == 0) ? 8'h4A : 8'h8A);
      poll(1);
    end
    w(`OFS_CTRL, 8'h00);
    w(`OFS_COUNT, 8'h05);
    rchk(`OFS_STATUS, 32'h0);
    // event counter mode, active high, external enable
    w(`OFS_CTRL, 8'h0D);
    core_pin_model_inst.pulse(1'b1, 2);
    rchk(`OFS_COUNT, 32'h3);
    rchk(`OFS_STATUS, 32'h1);
    w(`OFS_CTRL, 8'h0C);
    rchk(`OFS_STATUS, 32'h0);
    w(`OFS_CTRL, 8'h04);
    core_pin_model_inst.pulse(1'b1, 1);
    rchk(`OFS_COUNT, 32'h3);
    core_pin_model_inst.set_pin(1'b1);
    w(`OFS_CTRL, 8'h08);
    core_pin_model_inst.pulse(1'b0, 1);
    rchk(`OFS_COUNT, 32'h2);
    // polarity restored before the pin drops, no stray edge
    w(`OFS_CTRL, 8'h04);
    core_pin_model_inst.set_pin(1'b0);
    // pulse-width mode
    w(`OFS_COUNT, 8'h10);
    w(`OFS_CTRL, 8'h3D);
    repeat (20) @(posedge aclk);
    rchk(`OFS_COUNT, 32'h10);
    core_pin_model_inst.set_pin(1'b1);
    repeat (30) @(posedge aclk);
    rchk(`OFS_STATUS, 32'h4);
    rd(`OFS_COUNT, d, r);
    chk({31'h0, d < 32'h10}, 32'h1);
    core_pin_model_inst.set_pin(1'b0);
    repeat (8) @(posedge aclk);
    rchk(`OFS_STATUS, 32'h1);
    rd(`OFS_COUNT, d, r);
    repeat (20) @(posedge aclk);
    rchk(`OFS_COUNT, d);
    // both requests pending, then allowed
    w(`OFS_COUNT, 8'h01);
    w(`OFS_CTRL, 8'h2F);
    poll(1);
    w(`OFS_CTRL, 8'h07);
    repeat (20) @(posedge aclk);
    chk({30'h0, irq_state}, {30'h0, ST_IDLE});
    rchk(`OFS_STATUS, 32'h3);
    w(`OFS_ALLOW, 8'h01);
    wait_vec();
    chk({20'h0, v}, {20'h0, `VEC_TIMER});
    repeat (2) @(posedge aclk);
    chk({16'h0, stack_reg}, {16'h0, RET});
    chk({31'h0, irq_pending}, 32'h1);
    wait_vec();
    chk({20'h0, v}, {20'h0, `VEC_EXT});
    repeat (3) @(posedge aclk);
    rchk(`OFS_STATUS, 32'h8);
    rst(2);
    for (i = 0; i < 5; i++) rchk(8'(i * 4), 32'h0);
    close_out();
  end
endmodule
